// *** rtl/cmp_regs_pkg.sv ***
/*
 Constants for the comparator input and mode register block: register addresses, field positions,
 reset values and the port pins that feed each input selector.
 Assumes an 8-bit special function register bus with the addresses below.
*/
package cmp_regs_pkg;
   // Register addresses on the special function register bus.
   localparam logic [7:0] ADDR_MODE_IRQ_ENABLE = 8'h9d;
   localparam logic [7:0] ADDR_INPUT_SELECT = 8'h9f;

   // Reset values.
   localparam logic [7:0] RESET_MODE_IRQ_ENABLE = 8'h02;
   localparam logic [7:0] RESET_INPUT_SELECT = 8'h00;
   localparam logic [1:0] RESET_RESPONSE_MODE = 2'h2;

   // Field positions of the mode and interrupt enable register.
   localparam int RISING_IRQ_ENABLE_BIT = 5;
   localparam int FALLING_IRQ_ENABLE_BIT = 4;
   localparam int RESPONSE_MODE_LSB = 0;

   // Field positions of the input select register.
   localparam int NEG_SEL_LSB = 4;
   localparam int POS_SEL_LSB = 0;

   // Bits that hold storage; all others read as zero and ignore writes.
   localparam logic [7:0] MASK_MODE_IRQ_ENABLE = 8'h33;
   localparam logic [7:0] MASK_INPUT_SELECT = 8'h33;

   // Pin numbers inside port 1 and port 2 that feed the negative and positive inputs.
   localparam int NEG_PIN_LOW = 1;
   localparam int NEG_PIN_HIGH = 5;
   localparam int POS_PIN_LOW = 0;
   localparam int POS_PIN_HIGH = 4;

   // Selector codes.
   localparam logic [1:0] SEL_P1_LOW = 2'h0;
   localparam logic [1:0] SEL_P1_HIGH = 2'h1;
   localparam logic [1:0] SEL_P2_LOW = 2'h2;
   localparam logic [1:0] SEL_P2_HIGH = 2'h3;

   // Response modes, fastest first.
   typedef enum logic [1:0] {
      MODE_FASTEST = 2'b00,
      MODE_FAST = 2'b01,
      MODE_LOW_POWER = 2'b10,
      MODE_LOWEST_POWER = 2'b11
   } response_mode_t;
endpackage : cmp_regs_pkg

// *** rtl/pin_select.sv ***
/*
 Four-way registered pin selector for one comparator input.
 Assumes the four candidate pin levels are synchronous to the clock.
*/
module pin_select
   import cmp_regs_pkg::*;
(
   // Clock and control.
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Selection.
   input wire logic [1:0] sel,
   input wire logic [3:0] candidates,
   // Selected level.
   output logic chosen
);
   typedef struct packed {
      logic chosen;
   } sel_state_t;

   sel_state_t state_reg;
   sel_state_t state_next;

   always_comb begin
      state_next = state_reg;
      state_next.chosen = candidates[sel];
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign chosen = state_reg.chosen;
endmodule : pin_select

// *** rtl/comparator_input_mode_regs.sv ***
/*
 Register block for one voltage comparator: input pin selectors, edge interrupt enables and the
 response mode field, reached as special function registers.
 Assumes a single core clock, a synchronous active-high reset and single-cycle register strobes.
*/
module comparator_input_mode_regs
   import cmp_regs_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Register bus.
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // Port pin levels.
   input wire logic [7:0] port1_pins,
   input wire logic [7:0] port2_pins,
   // Comparator side.
   input wire logic rise_event,
   input wire logic fall_event,
   output logic neg_input,
   output logic pos_input,
   output logic [1:0] response_mode,
   output logic rise_irq_req,
   output logic fall_irq_req
);
   typedef struct packed {
      logic [1:0] neg_sel;
      logic [1:0] pos_sel;
      logic rising_edge_irq_enable;
      logic falling_edge_irq_enable;
      response_mode_t mode;
      logic [7:0] rdata;
      logic rise_irq;
      logic fall_irq;
   } regs_state_t;

   regs_state_t state_reg;
   regs_state_t state_next;
   logic [7:0] mode_word;
   logic [7:0] select_word;
   logic [3:0] neg_candidates;
   logic [3:0] pos_candidates;

   // Only the implemented bits are assembled; the rest stay zero.
   always_comb begin
      mode_word = '0;
      mode_word[RISING_IRQ_ENABLE_BIT] = state_reg.rising_edge_irq_enable;
      mode_word[FALLING_IRQ_ENABLE_BIT] = state_reg.falling_edge_irq_enable;
      mode_word[RESPONSE_MODE_LSB +: 2] = state_reg.mode;
      select_word = '0;
      select_word[NEG_SEL_LSB +: 2] = state_reg.neg_sel;
      select_word[POS_SEL_LSB +: 2] = state_reg.pos_sel;
   end

   always_comb begin
      state_next = state_reg;
      if (sfr_wr && sfr_addr == ADDR_MODE_IRQ_ENABLE) begin
         state_next.rising_edge_irq_enable = sfr_wdata[RISING_IRQ_ENABLE_BIT];
         state_next.falling_edge_irq_enable = sfr_wdata[FALLING_IRQ_ENABLE_BIT];
         state_next.mode = response_mode_t'(sfr_wdata[RESPONSE_MODE_LSB +: 2]);
      end
      if (sfr_wr && sfr_addr == ADDR_INPUT_SELECT) begin
         state_next.neg_sel = sfr_wdata[NEG_SEL_LSB +: 2];
         state_next.pos_sel = sfr_wdata[POS_SEL_LSB +: 2];
      end
      // Unmapped addresses answer zero so a stray read never shows stale data.
      if (sfr_rd) begin
         case (sfr_addr)
            ADDR_MODE_IRQ_ENABLE: begin
               state_next.rdata = mode_word & MASK_MODE_IRQ_ENABLE;
            end
            ADDR_INPUT_SELECT: begin
               state_next.rdata = select_word & MASK_INPUT_SELECT;
            end
            default: begin
               state_next.rdata = '0;
            end
         endcase
      end
      // The enable in force when the event arrives decides, so a write in the same cycle acts one later.
      state_next.rise_irq = rise_event && state_reg.rising_edge_irq_enable;
      state_next.fall_irq = fall_event && state_reg.falling_edge_irq_enable;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg.neg_sel <= RESET_INPUT_SELECT[NEG_SEL_LSB +: 2];
         state_reg.pos_sel <= RESET_INPUT_SELECT[POS_SEL_LSB +: 2];
         state_reg.rising_edge_irq_enable <= RESET_MODE_IRQ_ENABLE[RISING_IRQ_ENABLE_BIT];
         state_reg.falling_edge_irq_enable <= RESET_MODE_IRQ_ENABLE[FALLING_IRQ_ENABLE_BIT];
         state_reg.mode <= response_mode_t'(RESET_RESPONSE_MODE);
         state_reg.rdata <= '0;
         state_reg.rise_irq <= 1'b0;
         state_reg.fall_irq <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // Candidate pins in selector-code order.
   always_comb begin
      neg_candidates = {port2_pins[NEG_PIN_HIGH], port2_pins[NEG_PIN_LOW],
                        port1_pins[NEG_PIN_HIGH], port1_pins[NEG_PIN_LOW]};
      pos_candidates = {port2_pins[POS_PIN_HIGH], port2_pins[POS_PIN_LOW],
                        port1_pins[POS_PIN_HIGH], port1_pins[POS_PIN_LOW]};
   end

   pin_select neg_mux (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .sel(state_reg.neg_sel),
      .candidates(neg_candidates),
      .chosen(neg_input)
   );

   pin_select pos_mux (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .sel(state_reg.pos_sel),
      .candidates(pos_candidates),
      .chosen(pos_input)
   );

   assign sfr_rdata = state_reg.rdata;
   assign response_mode = state_reg.mode;
   assign rise_irq_req = state_reg.rise_irq;
   assign fall_irq_req = state_reg.fall_irq;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence write_select_s;
      ce && sfr_wr && sfr_addr == ADDR_INPUT_SELECT;
   endsequence

   sequence write_mode_s;
      ce && sfr_wr && sfr_addr == ADDR_MODE_IRQ_ENABLE;
   endsequence

   sequence two_quiet_cycles_s;
      ce && !(sfr_wr && sfr_addr == ADDR_INPUT_SELECT) ##1 ce;
   endsequence

   // A new selection reaches the pin output two edges after its write: one to store it, one to sample.
   chk_neg_pin_route: assert property (
      write_select_s ##1 two_quiet_cycles_s |-> neg_input == $past(neg_candidates[state_reg.neg_sel], 1))
      else $error("negative input not the selected pin");

   chk_neg_pin_follow: assert property (
      ce |=> neg_input == $past(neg_candidates[state_reg.neg_sel]))
      else $error("negative input does not follow its selector");

   chk_pos_pin_route: assert property (
      ce ##1 ce |-> pos_input == $past(pos_candidates[state_reg.pos_sel], 1))
      else $error("positive input not the selected pin");

   chk_neg_sel_store: assert property (
      write_select_s |=> state_reg.neg_sel == $past(sfr_wdata[NEG_SEL_LSB +: 2]))
      else $error("negative selector not stored on write");

   chk_pos_sel_store: assert property (
      write_select_s |=> state_reg.pos_sel == $past(sfr_wdata[POS_SEL_LSB +: 2]))
      else $error("positive selector not stored on write");

   chk_rise_irq_gate: assert property (
      ce |=> rise_irq_req == ($past(rise_event) && $past(mode_word[RISING_IRQ_ENABLE_BIT])))
      else $error("rising edge request not gated by its enable");

   chk_rise_enable_store: assert property (
      write_mode_s |=> state_reg.rising_edge_irq_enable == $past(sfr_wdata[RISING_IRQ_ENABLE_BIT]))
      else $error("rising edge enable not stored on write");

   chk_fall_irq_gate: assert property (
      ce |=> fall_irq_req == ($past(fall_event) && $past(mode_word[FALLING_IRQ_ENABLE_BIT])))
      else $error("falling edge request not gated by its enable");

   chk_fall_enable_store: assert property (
      write_mode_s |=> state_reg.falling_edge_irq_enable == $past(sfr_wdata[FALLING_IRQ_ENABLE_BIT]))
      else $error("falling edge enable not stored on write");

   chk_mode_after_reset: assert property (
      disable iff (1'b0) $fell(rst) |-> response_mode == MODE_LOW_POWER)
      else $error("response mode not two after reset");

   chk_mode_write: assert property (
      write_mode_s |=> response_mode == $past(sfr_wdata[RESPONSE_MODE_LSB +: 2]))
      else $error("response mode not stored on write");

   chk_mode_read_data: assert property (
      ce && sfr_rd && sfr_addr == ADDR_MODE_IRQ_ENABLE |=> sfr_rdata[RESPONSE_MODE_LSB +: 2] == $past(response_mode))
      else $error("response mode not returned on read");

   chk_unused_read_zero: assert property (
      ce && sfr_rd && (sfr_addr == ADDR_MODE_IRQ_ENABLE || sfr_addr == ADDR_INPUT_SELECT)
         |=> (sfr_rdata & ~(MASK_MODE_IRQ_ENABLE | MASK_INPUT_SELECT)) == '0)
      else $error("unused bits read nonzero");

   chk_unmapped_read: assert property (
      ce && sfr_rd && sfr_addr != ADDR_MODE_IRQ_ENABLE && sfr_addr != ADDR_INPUT_SELECT |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");

   chk_unmapped_write: assert property (
      ce && sfr_wr && sfr_addr != ADDR_MODE_IRQ_ENABLE && sfr_addr != ADDR_INPUT_SELECT
         |=> $stable(mode_word) && $stable(select_word))
      else $error("unmapped write changed a register");

   chk_freeze_hold: assert property (
   // Reset stays out of this check because it does not wait for the clock enable.
      !ce |=> $stable(sfr_rdata) && $stable(response_mode) && $stable(rise_irq_req) && $stable(fall_irq_req) &&
         $stable(neg_input) && $stable(pos_input))
      else $error("state moved while clock enable low");
endmodule : comparator_input_mode_regs

// *** bench/tb.sv ***
/*
 Self-checking bench for the comparator input and mode register block.
 Assumes the block's package and module are compiled first; the bench drives every port itself.
*/
module tb import cmp_regs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst, ce, sfr_wr, sfr_rd, rise_event, fall_event;
   logic [7:0] sfr_addr, sfr_wdata, port1_pins, port2_pins, sfr_rdata;
   logic neg_input, pos_input, rise_irq_req, fall_irq_req;
   logic [1:0] response_mode;
   int failures, check_count, i, seed;
   logic [7:0] v, s, r, d, p, q;

   comparator_input_mode_regs u_dut (
      .clock(clock), .rst(rst), .ce(ce),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .port1_pins(port1_pins), .port2_pins(port2_pins),
      .rise_event(rise_event), .fall_event(fall_event),
      .neg_input(neg_input), .pos_input(pos_input), .response_mode(response_mode),
      .rise_irq_req(rise_irq_req), .fall_irq_req(fall_irq_req)
   );

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   // Strobes drop one cycle before the next transfer so no signal is set twice at one edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      sfr_addr = a;
      sfr_wdata = dat;
      sfr_wr = 1'b1;
      @(negedge clock);
      sfr_wr = 1'b0;
      @(negedge clock);
   endtask : wr

   // Read data is taken a full cycle late; it stands until the next read.
   task automatic rd(input logic [7:0] a, output logic [7:0] dat);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clock);
      sfr_rd = 1'b0;
      @(negedge clock);
      dat = sfr_rdata;
   endtask : rd

   // Expected pin: the code's high bit picks the port, its low bit the upper pin pair.
   function automatic logic pick(input logic [1:0] code, input logic neg);
      logic [7:0] port;
      port = code[1] ? port2_pins : port1_pins;
      return port[{code[0], 1'b0, neg}];
   endfunction : pick

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   initial begin
      #100000;
      failures++;
      stop_test();
   end

   initial begin
      rst = 1'b1; ce = 1'b1; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
      port1_pins = 8'h00; port2_pins = 8'h00; rise_event = 1'b0; fall_event = 1'b0;
      failures = 0; check_count = 0;
      seed = $urandom(17);
      repeat (12) @(negedge clock);
      rst = 1'b0;
      rd(ADDR_MODE_IRQ_ENABLE, d);
      check("mode_reg", d, RESET_MODE_IRQ_ENABLE);
      check("response_mode", {6'h0, response_mode}, {6'h0, RESET_RESPONSE_MODE});
      rd(ADDR_INPUT_SELECT, d);
      check("select_reg", d, RESET_INPUT_SELECT);
      rd(8'h9e, d);
      check("unmapped_read", d, 8'h00);
      for (i = 0; i < 16; i++) begin
         v = (i < 4) ? {2'h3, 2'(i), 2'h3, 2'(i)} : 8'($urandom);
         wr(ADDR_MODE_IRQ_ENABLE, v);
         wr(ADDR_INPUT_SELECT, ~v);
         wr(8'h9e, 8'hff);
         rd(ADDR_MODE_IRQ_ENABLE, d);
         check("mode_reg", d, v & 8'h33);
         check("response_mode", {6'h0, response_mode}, {6'h0, v[1:0]});
         rd(ADDR_INPUT_SELECT, d);
         check("select_reg", d, ~v & 8'h33);
      end
      // Every selector code is reached by the sweep; random codes follow it.
      for (i = 0; i < 32; i++) begin
         s = (i < 4) ? {2'h0, 2'(i), 2'h0, 2'(3 - i)} : 8'($urandom);
         wr(ADDR_INPUT_SELECT, s);
         repeat (2) begin
            port1_pins = 8'($urandom);
            port2_pins = 8'($urandom);
            @(negedge clock);
            check("neg_input", {7'h0, neg_input}, {7'h0, pick(s[5:4], 1'b1)});
            check("pos_input", {7'h0, pos_input}, {7'h0, pick(s[1:0], 1'b0)});
         end
      end
      // Events arrive on two cycles in a row to catch a request that lingers.
      for (i = 0; i < 24; i++) begin
         v = (i < 4) ? {2'h0, 2'(i), 4'h0} : 8'($urandom);
         r = (i < 4) ? 8'h0f : 8'($urandom);
         wr(ADDR_MODE_IRQ_ENABLE, v);
         rise_event = r[0];
         fall_event = r[1];
         @(negedge clock);
         rise_event = r[2];
         fall_event = r[3];
         check("rise_irq_req", {7'h0, rise_irq_req}, {7'h0, r[0] & v[5]});
         check("fall_irq_req", {7'h0, fall_irq_req}, {7'h0, r[1] & v[4]});
         @(negedge clock);
         rise_event = 1'b0;
         fall_event = 1'b0;
         check("rise_irq_req", {7'h0, rise_irq_req}, {7'h0, r[2] & v[5]});
         check("fall_irq_req", {7'h0, fall_irq_req}, {7'h0, r[3] & v[4]});
         @(negedge clock);
         check("rise_irq_req", {7'h0, rise_irq_req}, 8'h00);
         check("fall_irq_req", {7'h0, fall_irq_req}, 8'h00);
      end
      // With the clock enable low, strobes, events and new pin levels must leave no trace.
      rd(ADDR_INPUT_SELECT, r);
      rd(ADDR_MODE_IRQ_ENABLE, d);
      v = {6'h0, response_mode};
      s = {7'h0, neg_input};
      p = {7'h0, pos_input};
      ce = 1'b0;
      port1_pins = ~port1_pins;
      port2_pins = ~port2_pins;
      rise_event = 1'b1;
      fall_event = 1'b1;
      wr(ADDR_INPUT_SELECT, ~r);
      wr(ADDR_MODE_IRQ_ENABLE, ~d);
      rd(ADDR_INPUT_SELECT, q);
      check("frozen_rdata", q, d);
      check("frozen_mode", {6'h0, response_mode}, v);
      check("frozen_neg", {7'h0, neg_input}, s);
      check("frozen_pos", {7'h0, pos_input}, p);
      check("frozen_rise", {7'h0, rise_irq_req}, 8'h00);
      check("frozen_fall", {7'h0, fall_irq_req}, 8'h00);
      ce = 1'b1;
      rise_event = 1'b0;
      fall_event = 1'b0;
      rd(ADDR_INPUT_SELECT, q);
      check("select_reg", q, r);
      rd(ADDR_MODE_IRQ_ENABLE, q);
      check("mode_reg", q, d);
      // A second reset from a dirty state must restore the read data, the response mode and both register reset values.
      wr(ADDR_MODE_IRQ_ENABLE, 8'h31);
      wr(ADDR_INPUT_SELECT, 8'h33);
      rd(ADDR_INPUT_SELECT, q);
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      check("rdata_after_reset", sfr_rdata, 8'h00);
      check("response_mode", {6'h0, response_mode}, {6'h0, RESET_RESPONSE_MODE});
      rd(ADDR_MODE_IRQ_ENABLE, q);
      check("mode_reg", q, RESET_MODE_IRQ_ENABLE);
      rd(ADDR_INPUT_SELECT, q);
      check("select_reg", q, RESET_INPUT_SELECT);
      stop_test();
   end
endmodule : tb
